// File: bench/cpf_dev_model.sv
// far-side device model: takes command frames off the byte link, answers those that request an acknowledge and are not dropped
// assumes no prefix or postfix bytes and payloads of at most 64 bytes
`timescale 1ns/1ps
module cpf_dev_model (
  input  wire        clk_i,
  input  wire        rst_b_i,
  input  wire        tx_valid_i,
  input  wire [7:0]  tx_data_i,
  output reg         tx_ready_o,
  output reg         rx_valid_o,
  output reg  [7:0]  rx_data_o,
  output reg         rx_last_o,
  input  wire [15:0] ack_status_i,
  input  wire [15:0] ack_len_i,
  input  wire [3:0]  drop_i,
  input  wire [3:0]  bad_i,
  input  wire        slow_i,
  input  wire        clr_i,
  output reg  [7:0]  n_frames_o
);
  reg  [7:0]  frm [0:79];
  reg  [6:0]  cnt;
  reg  [6:0]  rix;
  reg  [1:0]  gap;
  reg         snd;
  reg         bad;
  wire [15:0] flen = {frm[5], frm[4]} + 16'h0008;
  wire [6:0]  rend = ack_len_i[6:0] + 7'h07;

  function [7:0] rbyte(input [6:0] i);
    reg [15:0] w;
    begin
      case (i[2:1])
        2'h0: w = ack_status_i;
        2'h1: w = {frm[3], frm[2]} | 16'h0001;
        2'h2: w = ack_len_i;
        default: w = {frm[7], frm[6]} ^ {8'h00, {8{bad}}};
      endcase
      rbyte = (i > 7'h07) ? 8'h98 + {1'b0, i} : (i[0] ? w[15:8] : w[7:0]);
    end
  endfunction

  always @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      tx_ready_o <= 1'b0;
      rx_valid_o <= 1'b0;
      rx_data_o  <= 8'h00;
      rx_last_o  <= 1'b0;
      n_frames_o <= 8'h00;
      cnt        <= 7'h00;
      rix        <= 7'h00;
      gap        <= 2'h0;
      snd        <= 1'b0;
      bad        <= 1'b0;
    end
    else
    begin
      tx_ready_o <= slow_i ? ~tx_ready_o : 1'b1;
      if (clr_i)
        n_frames_o <= 8'h00;
      if (tx_valid_i && tx_ready_o)
      begin
        frm[cnt] <= tx_data_i;
        cnt      <= cnt + 7'h01;
        if (cnt >= 7'h07 && {9'h000, cnt} + 16'h0001 == flen)
        begin
          cnt        <= 7'h00;
          n_frames_o <= n_frames_o + 8'h01;
          bad        <= n_frames_o < {4'h0, bad_i};
          if (frm[1][6] && n_frames_o >= {4'h0, drop_i})
            gap <= 2'h3;
        end
      end
      if (gap != 2'h0)
        gap <= gap - 2'h1;
      if (gap == 2'h1)
        snd <= 1'b1;
      if (snd)
      begin
        rx_valid_o <= 1'b1;
        rx_data_o  <= rbyte(rix);
        rx_last_o  <= rix == rend;
        rix        <= (rix == rend) ? 7'h00 : rix + 7'h01;
        if (rix == rend)
          snd <= 1'b0;
      end
      else
      begin
        rx_valid_o <= 1'b0;
        rx_last_o  <= 1'b0;
        rx_data_o  <= ~rx_data_o; // idle data keeps moving so nothing stale passes
      end
    end
  end
endmodule

// File: bench/cpf_host_monitor.sv
// checker for cpf_host: handshake and status relations at the host ports
// assumes one clock and the active-low asynchronous reset of the host
`timescale 1ns/1ps
module cpf_host_monitor (
  input wire        clk_i,
  input wire        rst_b_i,
  input wire        cmd_valid_i,
  input wire        cmd_ready_o,
  input wire [15:0] cmd_len_i,
  input wire        cmd_ack_req_i,
  input wire        pay_ready_o,
  input wire        tx_valid_o,
  input wire [7:0]  tx_data_o,
  input wire        tx_ready_i,
  input wire        rx_valid_i,
  input wire        rsp_valid_o,
  input wire        done_o,
  input wire [15:0] done_status_o,
  input wire        done_err_o,
  input wire        done_fail_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  wire take = cmd_valid_i && cmd_ready_o;
  a_busy_after_take: assert property (take && cmd_len_i <= 16'h0040 |=> !cmd_ready_o)
    else $error("ready stayed high after a command was taken");
  a_ready_after_done: assert property (done_o |-> cmd_ready_o)
    else $error("not idle after done");
  a_tx_byte_hold: assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o))
    else $error("link byte changed before it was taken");
  a_flags_low_zero: assert property (take && cmd_len_i == 16'h0000 |-> ##2 tx_valid_o && tx_data_o == 8'h00)
    else $error("first flag byte not zero");
  a_flags_high_req: assert property (take && cmd_len_i == 16'h0000 ##2 tx_valid_o && tx_ready_i
    |=> tx_data_o == {1'b0, $past(cmd_ack_req_i, 3), 6'h00})
    else $error("second flag byte wrong");
  a_refuse_long: assert property (take && cmd_len_i > 16'h0040 |-> ##[1:2] done_o && done_fail_o)
    else $error("oversized payload not refused");
  a_fail_status: assert property (done_o && done_fail_o |-> done_err_o && done_status_o == 16'h0000)
    else $error("failed command reports wrong status");
  a_err_from_status: assert property (done_o && !done_fail_o |-> done_err_o == done_status_o[15])
    else $error("error flag disagrees with status");
  a_rsp_after_rx: assert property (rsp_valid_o |-> $past(rx_valid_i))
    else $error("payload byte without a received byte");
  a_load_not_idle: assert property (!(cmd_ready_o && pay_ready_o))
    else $error("payload taken while idle");
  c_take_ack: cover property (take && cmd_ack_req_i);
  c_done_fail: cover property (done_o && done_fail_o);
  c_rsp_byte: cover property (rsp_valid_o);
endmodule

bind cpf_host cpf_host_monitor i_cpf_host_monitor (.clk_i, .rst_b_i, .cmd_valid_i, .cmd_ready_o, .cmd_len_i,
  .cmd_ack_req_i, .pay_ready_o, .tx_valid_o, .tx_data_o, .tx_ready_i, .rx_valid_i, .rsp_valid_o, .done_o,
  .done_status_o, .done_err_o, .done_fail_o);

// File: bench/cpf_host_tb_top.sv
// testbench for cpf_host: issues commands and checks frames, replies, retries
// assumes cpf_dev_model as the device on the far side of the byte link
`timescale 1ns/1ps
module cpf_host_tb_top;
  reg         clk_i = 1'b0;
  reg         rst_b_i = 1'b0;
  reg         cmd_valid = 1'b0, cmd_ack_req = 1'b0, pay_valid = 1'b0, slow = 1'b0, clr = 1'b0;
  reg  [15:0] cmd_opcode = 16'h0000, cmd_len = 16'h0000, ack_status = 16'h0000, ack_len = 16'h0000;
  reg  [15:0] txn = 16'h0001;
  reg  [7:0]  pay_data = 8'h00;
  reg  [3:0]  drop = 4'h0, bad = 4'h0;
  integer     n_mismatch = 0, n_compared = 0, n_rsp;
  wire        cmd_ready, pay_ready, tx_valid, tx_ready, rx_valid, rx_last, rsp_valid;
  wire        done, done_err, done_fail;
  wire [7:0]  tx_data, rx_data, rsp_data, n_frames;
  wire [15:0] done_status, done_len, done_txn;

  // short timeout keeps the three-retry case brief
  cpf_host #(.ACK_TO_CYC(50)) i_cpf_host (.clk_i(clk_i), .rst_b_i(rst_b_i), .cmd_valid_i(cmd_valid),
    .cmd_ready_o(cmd_ready), .cmd_opcode_i(cmd_opcode), .cmd_len_i(cmd_len), .cmd_ack_req_i(cmd_ack_req),
    .pay_valid_i(pay_valid), .pay_data_i(pay_data), .pay_ready_o(pay_ready), .tx_valid_o(tx_valid),
    .tx_data_o(tx_data), .tx_ready_i(tx_ready), .rx_valid_i(rx_valid), .rx_data_i(rx_data), .rx_last_i(rx_last),
    .rsp_valid_o(rsp_valid), .rsp_data_o(rsp_data), .done_o(done), .done_status_o(done_status),
    .done_len_o(done_len), .done_txn_o(done_txn), .done_err_o(done_err), .done_fail_o(done_fail));
  cpf_dev_model i_cpf_dev_model (.clk_i(clk_i), .rst_b_i(rst_b_i), .tx_valid_i(tx_valid), .tx_data_i(tx_data),
    .tx_ready_o(tx_ready), .rx_valid_o(rx_valid), .rx_data_o(rx_data), .rx_last_o(rx_last),
    .ack_status_i(ack_status), .ack_len_i(ack_len), .drop_i(drop), .bad_i(bad), .slow_i(slow), .clr_i(clr),
    .n_frames_o(n_frames));

  always #5 clk_i = ~clk_i;

  task report_and_stop;
    begin
      if (n_mismatch == 0 && n_compared > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask

  task check(input [15:0] seen, input [15:0] exp);
    begin
      n_compared = n_compared + 1;
      if (seen !== exp)
      begin
        $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        n_mismatch = n_mismatch + 1;
      end
    end
  endtask

  function [7:0] fb(input integer k);
    fb = i_cpf_dev_model.frm[k];
  endfunction

  task chk_frame(input [15:0] op, input [15:0] len, input [7:0] fh);
    integer i;
    begin
      check({8'h00, fb(0)}, 16'h0000);
      check({8'h00, fb(1)}, {8'h00, fh});
      check({fb(3), fb(2)}, op);
      check({fb(5), fb(4)}, len);
      check({fb(7), fb(6)}, txn);
      for (i = 0; i < len; i = i + 1)
        check({8'h00, fb(8 + i)}, 16'h0010 + i[15:0]);
    end
  endtask

  task setup(input [3:0] d, input [3:0] b);
    begin
      drop = d;
      bad = b;
      clr = 1'b1;
      @(posedge clk_i);
      #1;
      clr = 1'b0;
    end
  endtask

  task run(input [15:0] op, input [15:0] len, input ack);
    integer i, k;
    reg     rdy;
    begin
      cmd_opcode = op;
      cmd_len = len;
      cmd_ack_req = ack;
      cmd_valid = 1'b1;
      @(posedge clk_i);
      #1;
      cmd_valid = 1'b0;
      txn = txn + 16'h0001;
      n_rsp = 0;
      i = 0;
      pay_data = 8'h10;
      pay_valid = len != 16'h0000 && len <= 16'h0040;
      for (k = 0; k < 200 && i < len && len <= 16'h0040; k = k + 1)
      begin
        rdy = pay_ready;
        @(posedge clk_i);
        #1;
        if (rdy)
        begin
          i = i + 1;
          pay_data = pay_data + 8'h01;
        end
      end
      pay_valid = 1'b0;
      for (k = 0; k < 3000 && done !== 1'b1; k = k + 1)
      begin
        @(posedge clk_i);
        #1;
        if (rsp_valid === 1'b1)
        begin
          check({8'h00, rsp_data}, 16'h00a0 + n_rsp[15:0]);
          n_rsp = n_rsp + 1;
        end
      end
      if (done !== 1'b1)
      begin
        n_mismatch = n_mismatch + 1;
        report_and_stop;
      end
    end
  endtask

  initial
  begin
    repeat (10) @(posedge clk_i);
    #1;
    rst_b_i = 1'b1;
    run(16'h0100, 16'h0000, 1'b0);
    chk_frame(16'h0100, 16'h0000, 8'h00);
    slow = 1'b1;
    ack_len = 16'h0002;
    run(16'h0802, 16'h0003, 1'b1);
    chk_frame(16'h0802, 16'h0003, 8'h40);
    check(done_len, 16'h0002);
    check(done_txn, txn);
    check(n_rsp[15:0], 16'h0002);
    slow = 1'b0;
    ack_len = 16'h0000;
    ack_status = 16'h8001;
    run(16'h0fff, 16'h0000, 1'b1);
    check(done_status, 16'h8001);
    check({15'h0000, done_err}, 16'h0001);
    ack_status = 16'h0000;
    setup(4'h1, 4'h0);
    run(16'h0804, 16'h0001, 1'b1);
    chk_frame(16'h0804, 16'h0001, 8'hc0);
    check({8'h00, n_frames}, 16'h0002);
    check({15'h0000, done_fail}, 16'h0000);
    setup(4'h0, 4'h1);
    run(16'h0806, 16'h0000, 1'b1);
    chk_frame(16'h0806, 16'h0000, 8'hc0);
    check({8'h00, n_frames}, 16'h0002);
    setup(4'h4, 4'h0);
    run(16'h0808, 16'h0000, 1'b1);
    check({8'h00, n_frames}, 16'h0004);
    check({15'h0000, done_fail}, 16'h0001);
    check(done_txn, txn);
    setup(4'h0, 4'h0);
    run(16'h0808, 16'h0041, 1'b1);
    check({15'h0000, done_fail}, 16'h0001);
    check({8'h00, n_frames}, 16'h0000);
    check(done_txn, txn);
    report_and_stop;
  end
endmodule

// File: logic/cpf_host.v
// host-side command framer: builds command packets, sends them as a byte
// stream, parses acknowledges and retries on timeout or corrupt replies.
// assumes a same-clock byte link with valid/ready out and valid/last in.
`timescale 1ns/1ps
`include "cpf_host_regs.vh"

module cpf_host #(
  parameter [15:0] PREFIX_BYTES  = 16'h0000,
  parameter [15:0] POSTFIX_BYTES = 16'h0000,
  parameter        PAY_AW        = 6,
  parameter        ACK_TO_CYC    = `CPF_ACK_TIMEOUT_CYC
) (
  input  wire        clk_i,
  input  wire        rst_b_i,
  input  wire        cmd_valid_i,
  output wire        cmd_ready_o,
  input  wire [15:0] cmd_opcode_i,
  input  wire [15:0] cmd_len_i,
  input  wire        cmd_ack_req_i,
  input  wire        pay_valid_i,
  input  wire [7:0]  pay_data_i,
  output wire        pay_ready_o,
  output reg         tx_valid_o,
  output reg  [7:0]  tx_data_o,
  input  wire        tx_ready_i,
  input  wire        rx_valid_i,
  input  wire [7:0]  rx_data_i,
  input  wire        rx_last_i,
  output reg         rsp_valid_o,
  output reg  [7:0]  rsp_data_o,
  output reg         done_o,
  output reg  [15:0] done_status_o,
  output reg  [15:0] done_len_o,
  output reg  [15:0] done_txn_o,
  output reg         done_err_o,
  output reg         done_fail_o
);

  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_LOAD = 3'h1;
  localparam [2:0] ST_SEND = 3'h2;
  localparam [2:0] ST_WAIT = 3'h3;
  localparam [2:0] ST_EVAL = 3'h4;
  localparam [31:0] TO_LAST = ACK_TO_CYC - 1;
  localparam [16:0] MAX_PAY = 17'h00001 << PAY_AW;

  function [7:0] le_byte;
    input [15:0] w;
    input        hi;
    begin
      le_byte = hi ? w[15:8] : w[7:0];
    end
  endfunction

  reg  [2:0]        state;
  reg  [15:0]       opcode;
  reg  [15:0]       len;
  reg               ack_request_flag;
  reg               resend_flag;
  reg  [15:0]       transaction_number;
  reg  [3:0]        retry;
  reg  [31:0]       tmo;
  reg  [15:0]       load_idx;
  reg  [15:0]       tx_idx;
  reg  [7:0]        tx_sum;
  reg  [7:0]        pay_mem [0:(1<<PAY_AW)-1];
  reg  [15:0]       rx_cnt;
  reg  [15:0]       rx_st;
  reg  [15:0]       rx_op;
  reg  [15:0]       rx_ln;
  reg  [15:0]       rx_tn;
  reg  [7:0]        rx_sum;
  reg  [7:0]        rx_pst;
  reg  [7:0]        next_byte;

  wire [15:0] flags    = {resend_flag, ack_request_flag, `CPF_FLAGS_RSVD};
  wire [15:0] tx_total = PREFIX_BYTES + `CPF_COMMON_BYTES + len + POSTFIX_BYTES;
  wire [15:0] tx_rel   = tx_idx - PREFIX_BYTES;
  wire [15:0] tx_pay   = tx_rel - `CPF_COMMON_BYTES;
  wire        tx_pre   = tx_idx < PREFIX_BYTES;
  wire        tx_body  = !tx_pre && (tx_rel < `CPF_COMMON_BYTES || tx_pay < len);
  wire [15:0] rx_rel   = rx_cnt - PREFIX_BYTES;
  wire [15:0] rx_pay   = rx_rel - `CPF_COMMON_BYTES;
  wire        rx_pre   = rx_cnt < PREFIX_BYTES;
  wire        rx_hdr   = !rx_pre && rx_rel < `CPF_COMMON_BYTES;
  wire        rx_data  = !rx_pre && !rx_hdr && rx_pay < rx_ln;
  wire        rx_take  = rx_valid_i && state == ST_WAIT;
  wire [15:0] rx_want  = PREFIX_BYTES + `CPF_COMMON_BYTES + rx_ln + POSTFIX_BYTES;
  wire        ack_ok   = rx_cnt == rx_want
                         && rx_tn == transaction_number
                         && rx_op == (opcode | `CPF_ACK_MARK)
                         && (POSTFIX_BYTES == 16'h0000 || rx_pst == rx_sum);
  wire        timed_out = state == ST_WAIT && tmo == TO_LAST;
  wire        corrupt   = state == ST_EVAL && !ack_ok;
  wire        do_retry  = timed_out || corrupt;

  assign cmd_ready_o = state == ST_IDLE;
  assign pay_ready_o = state == ST_LOAD;

  // prefix filler, then common section, then payload, then postfix checksum
  always @*
  begin
    next_byte = 8'h00;
    if (tx_pre)
      next_byte = 8'h00;
    else if (tx_rel < `CPF_COMMON_BYTES)
    begin
      case (tx_rel[2:1])
        2'h0: next_byte = le_byte(flags, tx_rel[0]);
        2'h1: next_byte = le_byte(opcode, tx_rel[0]);
        2'h2: next_byte = le_byte(len, tx_rel[0]);
        2'h3: next_byte = le_byte(transaction_number, tx_rel[0]);
        default: next_byte = 8'h00;
      endcase
    end
    else if (tx_pay < len)
      next_byte = pay_mem[tx_pay[PAY_AW-1:0]];
    else
      next_byte = tx_sum;
  end

  always @(posedge clk_i)
  begin
    if (state == ST_LOAD && pay_valid_i)
      pay_mem[load_idx[PAY_AW-1:0]] <= pay_data_i;
  end

  always @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      state              <= ST_IDLE;
      opcode             <= 16'h0000;
      len                <= 16'h0000;
      ack_request_flag   <= 1'b0;
      resend_flag        <= 1'b0;
      transaction_number <= `CPF_TXN_RESET;
      retry              <= 4'h0;
      tmo                <= 32'h00000000;
      load_idx           <= 16'h0000;
      tx_idx             <= 16'h0000;
      tx_sum             <= 8'h00;
      tx_valid_o         <= 1'b0;
      tx_data_o          <= 8'h00;
      done_o             <= 1'b0;
      done_status_o      <= 16'h0000;
      done_len_o         <= 16'h0000;
      done_txn_o         <= 16'h0000;
      done_err_o         <= 1'b0;
      done_fail_o        <= 1'b0;
    end
    else
    begin
      done_o <= 1'b0;
      case (state)
        ST_IDLE:
        begin
          if (cmd_valid_i)
          begin
            opcode           <= cmd_opcode_i;
            len              <= cmd_len_i;
            ack_request_flag <= cmd_ack_req_i;
            resend_flag      <= 1'b0;
            retry            <= 4'h0;
            load_idx         <= 16'h0000;
            tx_idx           <= 16'h0000;
            tx_sum           <= 8'h00;
            // every new command gets a fresh number; only resends reuse one
            transaction_number <= transaction_number + 16'h0001;
            if ({1'b0, cmd_len_i} > MAX_PAY)
            begin
              // payload cannot be held for a resend, so refuse outright
              done_o        <= 1'b1;
              done_fail_o   <= 1'b1;
              done_err_o    <= 1'b1;
              done_status_o <= 16'h0000;
              done_len_o    <= 16'h0000;
              done_txn_o    <= transaction_number + 16'h0001;
            end
            else if (cmd_len_i == 16'h0000)
              state <= ST_SEND;
            else
              state <= ST_LOAD;
          end
        end
        ST_LOAD:
        begin
          if (pay_valid_i)
          begin
            load_idx <= load_idx + 16'h0001;
            if (load_idx == len - 16'h0001)
              state <= ST_SEND;
          end
        end
        ST_SEND:
        begin
          if (!tx_valid_o || tx_ready_i)
          begin
            if (tx_idx < tx_total)
            begin
              tx_valid_o <= 1'b1;
              tx_data_o  <= next_byte;
              tx_idx     <= tx_idx + 16'h0001;
              if (tx_body)
                tx_sum <= tx_sum + next_byte;
            end
            else
            begin
              tx_valid_o <= 1'b0;
              tmo        <= 32'h00000000;
              if (ack_request_flag)
                state <= ST_WAIT;
              else
              begin
                // nothing comes back, so report at once
                state         <= ST_IDLE;
                done_o        <= 1'b1;
                done_fail_o   <= 1'b0;
                done_err_o    <= 1'b0;
                done_status_o <= 16'h0000;
                done_len_o    <= 16'h0000;
                done_txn_o    <= transaction_number;
              end
            end
          end
        end
        ST_WAIT:
        begin
          tmo <= tmo + 32'h00000001;
          if (rx_take && rx_last_i)
            state <= ST_EVAL;
        end
        ST_EVAL:
        begin
          if (ack_ok)
          begin
            state         <= ST_IDLE;
            done_o        <= 1'b1;
            done_fail_o   <= 1'b0;
            done_status_o <= rx_st;
            done_err_o    <= rx_st[`CPF_STS_ERR_BIT];
            done_len_o    <= rx_ln;
            done_txn_o    <= rx_tn;
          end
        end
        default:
          state <= ST_IDLE;
      endcase
      // resend keeps the transaction number so the device can spot a repeat
      if (do_retry)
      begin
        if (retry == `CPF_RETRIES)
        begin
          state         <= ST_IDLE;
          done_o        <= 1'b1;
          done_fail_o   <= 1'b1;
          done_err_o    <= 1'b1;
          done_status_o <= 16'h0000;
          done_len_o    <= 16'h0000;
          done_txn_o    <= transaction_number;
        end
        else
        begin
          retry       <= retry + 4'h1;
          resend_flag <= 1'b1;
          tx_idx      <= 16'h0000;
          tx_sum      <= 8'h00;
          state       <= ST_SEND;
        end
      end
    end
  end

  // acknowledge parser; payload is forwarded before the packet is validated
  always @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      rx_cnt      <= 16'h0000;
      rx_st       <= 16'h0000;
      rx_op       <= 16'h0000;
      rx_ln       <= 16'h0000;
      rx_tn       <= 16'h0000;
      rx_sum      <= 8'h00;
      rx_pst      <= 8'h00;
      rsp_valid_o <= 1'b0;
      rsp_data_o  <= 8'h00;
    end
    else
    begin
      rsp_valid_o <= 1'b0;
      if (state == ST_EVAL || state == ST_SEND)
      begin
        rx_cnt <= 16'h0000;
        rx_sum <= 8'h00;
        rx_ln  <= 16'h0000;
      end
      else if (rx_take)
      begin
        rx_cnt <= rx_cnt + 16'h0001;
        if (rx_hdr || rx_data)
          rx_sum <= rx_sum + rx_data_i;
        else if (!rx_pre)
          rx_pst <= rx_data_i;
        if (rx_hdr)
        begin
          case (rx_rel[2:1])
            2'h0:
              if (rx_rel[0]) rx_st[15:8] <= rx_data_i; else rx_st[7:0] <= rx_data_i;
            2'h1:
              if (rx_rel[0]) rx_op[15:8] <= rx_data_i; else rx_op[7:0] <= rx_data_i;
            2'h2:
              if (rx_rel[0]) rx_ln[15:8] <= rx_data_i; else rx_ln[7:0] <= rx_data_i;
            default:
              if (rx_rel[0]) rx_tn[15:8] <= rx_data_i; else rx_tn[7:0] <= rx_data_i;
          endcase
        end
        if (rx_data)
        begin
          rsp_valid_o <= 1'b1;
          rsp_data_o  <= rx_data_i;
        end
      end
    end
  end

endmodule

// File: logic/cpf_host_regs.vh
// constants of the command/acknowledge framing used by the host controller
// assumes little-endian byte order on the link and a 100 MHz system clock
`ifndef CPF_HOST_REGS_VH
`define CPF_HOST_REGS_VH
`define CPF_COMMON_BYTES    16'h0008
`define CPF_OFS_FLAGS       3'h0
`define CPF_OFS_OPCODE      3'h2
`define CPF_OFS_LEN         3'h4
`define CPF_OFS_TXN         3'h6
`define CPF_OFS_STATUS      3'h0
`define CPF_BIT_ACK_REQ     14
`define CPF_BIT_RESEND      15
`define CPF_FLAGS_RSVD      14'h0000
`define CPF_STS_ERR_BIT     15
`define CPF_ACK_MARK        16'h0001
`define CPF_RETRIES         4'h3
`define CPF_TXN_RESET       16'h0001
`define CPF_CLK_PERIOD_NS   10
`define CPF_ACK_TIMEOUT_NS  1000000
`define CPF_ACK_TIMEOUT_CYC (`CPF_ACK_TIMEOUT_NS / `CPF_CLK_PERIOD_NS)
`endif
